/* File: logic/icd_decoder.sv */
`timescale 1ns/1ps
`include "icd_consts.svh"
// What this block does
// - Destination register number from bits 2:0
// - Destination mode bits 5:3, flag zero
// - Source register number from bits 8:6
// - Source mode bits 11:9, flag zero
// - Flag read-modify-write opcode set
// - Read-modify-write operand uses interlocked read-pause
// - Flag read-only operand opcode set
// - Flag write-only class, issues word write
// - Flag double-operand groups 01-06, 11-16
// - Flag destination calculation class
// - Flag execute-only class, no address calculation
// - Condition 6 picks write, read-pause or read
// - Condition 7 picks byte or word write
// - Flag jump and subroutine-call opcodes
// - Flag floating-point class, top digits 17
// - Jump-or-float uses one cycle fewer
// - Bus control 3 clears address, stack errors
// - Acknowledge clears pending trap and abort
// - Branch offset doubled and sign extended
// - Abort unneeded or unfinishable transfer
// - Register write updates both copies
// - Console halt flag stops processing
module icd_decoder
    import icd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire icd_apb_req_s apb_req,
    output icd_apb_rsp_s apb_rsp,
    input wire logic addr_err_evt,
    input wire logic stack_err_evt,
    input wire logic trap_evt,
    input wire logic abort_evt,
    input wire logic console_halt_flag,
    output icd_class_s class_flags,
    output icd_fields_s fields,
    output icd_bus_e bus_cycle,
    output logic xfer_start,
    output logic transfer_abort,
    output logic clear_flags,
    output logic service_acknowledge,
    output logic halted,
    output logic [1:0] post_dac_cycles,
    output logic [15:0] dest_side_rd,
    output logic [15:0] src_side_rd
);
    icd_state_s s_reg;
    icd_state_s s_next;
    icd_class_s cls;
    logic setup;
    logic wr_acc;
    logic [31:0] rd_mux;
    logic mapped;

    // Opcode classes from the instruction word alone
    function automatic icd_class_s decode(input logic [15:0] iw);
        icd_class_s c;
        logic [3:0] g;
        logic [5:0] op;
        logic [2:0] hi;
        logic zg;
        logic una;
        logic eis;
        g = iw[`ICD_GRP];
        op = iw[`ICD_OP6];
        hi = iw[`ICD_SMODE_F];
        zg = (iw[`ICD_MID] == 3'h0);
        eis = (g == 4'h7);
        una = zg && ((op >= `ICD_OP_CLR && op <= `ICD_OP_SBC)
            || (op >= `ICD_OP_ROR && op <= `ICD_OP_ASL));
        c = '0;
        c.dmz = (iw[`ICD_DMODE_F] == 3'h0);
        c.smz = (iw[`ICD_SMODE_F] == 3'h0);
        c.jmp = (g == 4'h0) && (op == `ICD_OP_JMP || op[5:3] == `ICD_OP_JSR);
        c.flt = (g == 4'hf);
        c.jf = c.jmp || c.flt;
        c.dbl = g inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
            4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
        c.rmw = una || (g == 4'h0 && (op == `ICD_OP_SWAB || op == `ICD_OP_SXT))
            || (eis && hi == `ICD_EIS_XOR)
            || g inside {4'h4, 4'h5, 4'h6, 4'h9, 4'hc, 4'hd, 4'he};
        c.rd_only = (zg && (op == `ICD_OP_TST || op == `ICD_OP_MFP))
            || (eis && hi <= `ICD_EIS_DIV)
            || g inside {4'h2, 4'h3, 4'ha, 4'hb};
        c.wr_only = (g == 4'h1) || (zg && op == `ICD_OP_MTP);
        // Group 16 is a word subtract despite its top bit
        c.byte_op = iw[`ICD_BYTE] && ((zg && op != `ICD_OP_MFP && op != `ICD_OP_MTP)
            || g inside {4'h9, 4'ha, 4'hb, 4'hc, 4'hd});
        c.dac = una || c.jmp || (zg && (op == `ICD_OP_TST || op == `ICD_OP_MFP))
            || (g == 4'h0 && (op == `ICD_OP_SWAB || op == `ICD_OP_SXT))
            || (eis && hi <= `ICD_EIS_XOR)
            || (c.dbl && c.smz);
        // Jumps with register mode are illegal, never execute-only
        c.exe = c.dac && c.dmz && !c.jmp;
        return c;
    endfunction

    // Bus cycle chosen by the bus condition and the class
    function automatic icd_bus_e bus_sel(input logic [2:0] bc, input icd_class_s c);
        icd_bus_e b;
        if (bc == `ICD_BC_OP1)
        begin
            if (c.wr_only)
                b = ICD_BUS_WRWORD;
            else if (c.rmw)
                b = ICD_BUS_RDPAUSE;
            else
                b = ICD_BUS_READ;
        end
        else if (bc == `ICD_BC_OP2)
            b = c.byte_op ? ICD_BUS_WRBYTE : ICD_BUS_WRWORD;
        else
            b = ICD_BUS_READ;
        return b;
    endfunction

    // Flags are pure decode of the stored word, valid in every state
    assign cls = decode(s_reg.iword);
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_acc = apb_req.psel && apb_req.penable && s_reg.rsp.pready && apb_req.pwrite;

    // Read data selected during the setup cycle
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (apb_req.paddr)
            `ICD_OFF_IWORD: rd_mux = {16'h0000, s_reg.iword};
            `ICD_OFF_UWORD: rd_mux = {26'h0, s_reg.bus_ctrl, s_reg.bus_cond};
            `ICD_OFF_CLASS: rd_mux = {15'h0, s_reg.bus, cls};
            `ICD_OFF_FIELDS: rd_mux = {4'h0, s_reg.fld};
            `ICD_OFF_CTRL: rd_mux = 32'h0000_0000;
            `ICD_OFF_STATUS: rd_mux = {27'h0, s_reg.run == ICD_HALT, s_reg.abort_pend,
                s_reg.trap_pend, s_reg.stack_err, s_reg.addr_err};
            `ICD_OFF_GRWR: rd_mux = 32'h0000_0000;
            `ICD_OFF_GRRD: rd_mux = {s_reg.scopy_rd, s_reg.dcopy_rd};
            default: mapped = 1'b0;
        endcase
    end

    // Next state of the whole block
    always_comb
    begin
        s_next = s_reg;
        s_next.go = 1'b0;
        s_next.abort = 1'b0;
        s_next.clr = 1'b0;
        s_next.ack = 1'b0;
        s_next.cls = cls;
        s_next.fld.dreg = s_reg.iword[`ICD_DREG_F];
        s_next.fld.dmode = s_reg.iword[`ICD_DMODE_F];
        s_next.fld.sreg = s_reg.iword[`ICD_SREG_F];
        s_next.fld.smode = s_reg.iword[`ICD_SMODE_F];
        s_next.fld.br_off = {{7{s_reg.iword[`ICD_DISP_SIGN]}},
            s_reg.iword[`ICD_DISP], 1'b0};
        s_next.tail = cls.jf ? `ICD_DAC_TAIL - 2'h1 : `ICD_DAC_TAIL;
        // Both read ports see the selected register of each copy
        s_next.dcopy_rd = s_reg.dcopy[s_reg.iword[`ICD_DREG_F]];
        s_next.scopy_rd = s_reg.scopy[s_reg.iword[`ICD_SREG_F]];
        // Bus slave: one wait-free access phase
        s_next.rsp.pready = setup;
        s_next.rsp.pslverr = setup && !mapped;
        if (setup)
            s_next.rsp.prdata = rd_mux;
        // Halt follows the console flag level
        unique case (s_reg.run)
            ICD_RUN:
                if (console_halt_flag)
                    s_next.run = ICD_HALT;
            ICD_HALT:
                if (!console_halt_flag)
                    s_next.run = ICD_RUN;
        endcase
        // Pending flags: a new event beats a clear in the same cycle
        s_next.addr_err = s_reg.addr_err || addr_err_evt;
        s_next.stack_err = s_reg.stack_err || stack_err_evt;
        s_next.trap_pend = s_reg.trap_pend || trap_evt;
        s_next.abort_pend = s_reg.abort_pend || abort_evt;
        if (wr_acc)
        begin
            unique case (apb_req.paddr)
                `ICD_OFF_IWORD: s_next.iword = apb_req.pwdata[15:0];
                `ICD_OFF_UWORD:
                begin
                    s_next.bus_cond = apb_req.pwdata[`ICD_UW_COND];
                    s_next.bus_ctrl = apb_req.pwdata[`ICD_UW_CTRL];
                    if (apb_req.pwdata[`ICD_UW_CTRL] == `ICD_BCT_CLR)
                    begin
                        s_next.clr = 1'b1;
                        s_next.addr_err = addr_err_evt;
                        s_next.stack_err = stack_err_evt;
                    end
                    if (apb_req.pwdata[`ICD_UW_GO] && s_reg.run == ICD_RUN)
                    begin
                        // A pending abort ends the transfer before it starts
                        if (s_reg.abort_pend || abort_evt)
                            s_next.abort = 1'b1;
                        else
                        begin
                            s_next.go = 1'b1;
                            s_next.bus = bus_sel(apb_req.pwdata[`ICD_UW_COND], cls);
                        end
                    end
                end
                `ICD_OFF_CTRL:
                begin
                    if (apb_req.pwdata[`ICD_CT_ACK])
                    begin
                        s_next.ack = 1'b1;
                        s_next.trap_pend = trap_evt;
                        s_next.abort_pend = abort_evt;
                    end
                    // Only a transfer begun the cycle before can be withdrawn
                    if (apb_req.pwdata[`ICD_CT_ABORT] && s_reg.go)
                        s_next.abort = 1'b1;
                end
                `ICD_OFF_GRWR:
                begin
                    s_next.dcopy[apb_req.pwdata[`ICD_GW_SEL]] =
                        apb_req.pwdata[`ICD_GW_DATA];
                    s_next.scopy[apb_req.pwdata[`ICD_GW_SEL]] =
                        apb_req.pwdata[`ICD_GW_DATA];
                end
                default:
                begin
                    s_next.bus = s_reg.bus;
                end
            endcase
        end
    end

    // All state in one register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.iword <= `ICD_IWORD_RST;
            s_reg.bus_cond <= `ICD_UWORD_RST;
            s_reg.bus_ctrl <= `ICD_UWORD_RST;
            s_reg.run <= ICD_RUN;
            s_reg.bus <= ICD_BUS_NONE;
            s_reg.cls.dmz <= 1'b1;
            s_reg.cls.smz <= 1'b1;
            s_reg.tail <= `ICD_DAC_TAIL;
        end
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign apb_rsp = s_reg.rsp;
    assign class_flags = s_reg.cls;
    assign fields = s_reg.fld;
    assign bus_cycle = s_reg.bus;
    assign xfer_start = s_reg.go;
    assign transfer_abort = s_reg.abort;
    assign clear_flags = s_reg.clr;
    assign service_acknowledge = s_reg.ack;
    assign halted = (s_reg.run == ICD_HALT);
    assign post_dac_cycles = s_reg.tail;
    assign dest_side_rd = s_reg.dcopy_rd;
    assign src_side_rd = s_reg.scopy_rd;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Field outputs trail the stored word by one cycle
    field_extract_a: assert property (
        ##1 fields.dreg == $past(s_reg.iword[2:0]) && fields.sreg == $past(s_reg.iword[8:6]))
        else $error("register fields do not follow word");
    mode_zero_a: assert property (
        ##1 class_flags.dmz == (fields.dmode == 3'h0) && class_flags.smz == (fields.smode == 3'h0))
        else $error("mode zero flags wrong");
    bsop_one_a: assert property (
        xfer_start && s_reg.bus_cond == 3'h6 |-> bus_cycle == (class_flags.wr_only ?
        ICD_BUS_WRWORD : class_flags.rmw ? ICD_BUS_RDPAUSE : ICD_BUS_READ))
        else $error("bus condition 6 cycle wrong");
    bsop_two_a: assert property (
        xfer_start && s_reg.bus_cond == 3'h7 |->
        bus_cycle == (class_flags.byte_op ? ICD_BUS_WRBYTE : ICD_BUS_WRWORD))
        else $error("bus condition 7 cycle wrong");
    flag_clear_a: assert property (
        clear_flags |-> s_reg.bus_ctrl == 3'h3 && (!s_reg.addr_err || $past(addr_err_evt)))
        else $error("clear control left address error set");
    ack_clear_a: assert property (
        service_acknowledge |-> !s_reg.trap_pend || $past(trap_evt))
        else $error("acknowledge left trap pending");
    halt_block_a: assert property (
        $past(halted) |-> !xfer_start)
        else $error("transfer started while halted");
    abort_cause_a: assert property (
        transfer_abort |-> $past(xfer_start) || $past(s_reg.abort_pend) || $past(abort_evt))
        else $error("abort without cause");
    dual_copy_a: assert property (
        s_reg.dcopy == s_reg.scopy)
        else $error("register copies differ");
    branch_off_a: assert property (
        ##1 fields.br_off == {{7{$past(s_reg.iword[7])}}, $past(s_reg.iword[7:0]), 1'b0})
        else $error("branch offset wrong");
    exec_class_a: assert property (
        class_flags.exe |-> class_flags.dac && class_flags.dmz && !class_flags.jmp)
        else $error("execute class without zero mode");
    fj_tail_a: assert property (
        ##1 $past(cls.jf) |-> post_dac_cycles == 2'h1)
        else $error("jump or float tail not shortened");
    // Pulses last one cycle and never overlap
    start_pulse_a: assert property (
        xfer_start |=> !xfer_start)
        else $error("transfer start longer than one cycle");
    abort_pulse_a: assert property (
        transfer_abort |=> !transfer_abort)
        else $error("abort longer than one cycle");
    start_abort_a: assert property (
        !(xfer_start && transfer_abort))
        else $error("transfer started and aborted together");
    rmw_pause_a: assert property (
        xfer_start && bus_cycle == ICD_BUS_RDPAUSE |-> class_flags.rmw)
        else $error("read-pause for a word outside the modify class");
    dbl_dac_a: assert property (
        class_flags.dbl && class_flags.smz |-> class_flags.dac)
        else $error("double operand with zero source mode not flagged");
    // Sticky flags rise only on their own event
    addr_set_a: assert property (
        $rose(s_reg.addr_err) |-> $past(addr_err_evt))
        else $error("address error set without event");
    trap_set_a: assert property (
        $rose(s_reg.trap_pend) |-> $past(trap_evt))
        else $error("trap pending set without event");
    // Halt state trails the console flag by one cycle
    halt_follow_a: assert property (
        halted == $past(console_halt_flag))
        else $error("halt state does not follow console flag");

    read_pause_c: cover property (xfer_start && bus_cycle == ICD_BUS_RDPAUSE);
    byte_write_c: cover property (xfer_start && bus_cycle == ICD_BUS_WRBYTE);
    late_abort_c: cover property (xfer_start ##1 transfer_abort);
    halt_c: cover property (halted ##1 !halted);
    flag_clear_c: cover property (clear_flags);
endmodule

/* File: pkg/icd_consts.svh */
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH
// Register byte offsets
`define ICD_OFF_IWORD 5'h00
`define ICD_OFF_UWORD 5'h04
`define ICD_OFF_CLASS 5'h08
`define ICD_OFF_FIELDS 5'h0c
`define ICD_OFF_CTRL 5'h10
`define ICD_OFF_STATUS 5'h14
`define ICD_OFF_GRWR 5'h18
`define ICD_OFF_GRRD 5'h1c
// Instruction word fields
`define ICD_DREG_F 2:0
`define ICD_DMODE_F 5:3
`define ICD_SREG_F 8:6
`define ICD_SMODE_F 11:9
`define ICD_OP6 11:6
`define ICD_GRP 15:12
`define ICD_MID 14:12
`define ICD_BYTE 15
`define ICD_DISP 7:0
`define ICD_DISP_SIGN 7
// Microword register fields
`define ICD_UW_COND 2:0
`define ICD_UW_CTRL 5:3
`define ICD_UW_GO 8
// Control register bits
`define ICD_CT_ACK 0
`define ICD_CT_ABORT 1
// General register write port fields
`define ICD_GW_DATA 15:0
`define ICD_GW_SEL 18:16
// Microword codes
`define ICD_BC_OP1 3'h6
`define ICD_BC_OP2 3'h7
`define ICD_BCT_CLR 3'h3
// Reset values
`define ICD_IWORD_RST 16'h0000
`define ICD_UWORD_RST 3'h0
// Cycles after the destination calculation
`define ICD_DAC_TAIL 2'h2
// Single-operand opcodes, bits 11:6
`define ICD_OP_JMP 6'h01
`define ICD_OP_SWAB 6'h03
`define ICD_OP_JSR 3'h4
`define ICD_OP_CLR 6'h28
`define ICD_OP_SBC 6'h2e
`define ICD_OP_TST 6'h2f
`define ICD_OP_ROR 6'h30
`define ICD_OP_ASL 6'h33
`define ICD_OP_MFP 6'h35
`define ICD_OP_MTP 6'h36
`define ICD_OP_SXT 6'h37
// Register-to-destination group, bits 11:9
`define ICD_EIS_DIV 3'h1
`define ICD_EIS_XOR 3'h4
`endif

/* File: pkg/icd_pkg.sv */
`include "icd_consts.svh"
package icd_pkg;
    // Bus cycle requested from the transfer control
    typedef enum logic [4:0] {
        ICD_BUS_NONE = 5'h01,
        ICD_BUS_READ = 5'h02,
        ICD_BUS_RDPAUSE = 5'h04,
        ICD_BUS_WRWORD = 5'h08,
        ICD_BUS_WRBYTE = 5'h10
    } icd_bus_e;
    // Run state, follows the console halt flag
    typedef enum logic [1:0] {
        ICD_RUN = 2'h1,
        ICD_HALT = 2'h2
    } icd_run_e;
    typedef struct packed {
        logic [4:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } icd_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } icd_apb_rsp_s;
    typedef struct packed {
        logic rmw;
        logic rd_only;
        logic wr_only;
        logic dbl;
        logic dac;
        logic exe;
        logic jmp;
        logic flt;
        logic jf;
        logic byte_op;
        logic dmz;
        logic smz;
    } icd_class_s;
    typedef struct packed {
        logic [2:0] dreg;
        logic [2:0] dmode;
        logic [2:0] sreg;
        logic [2:0] smode;
        logic [15:0] br_off;
    } icd_fields_s;
    typedef struct packed {
        logic [15:0] iword;
        logic [2:0] bus_cond;
        logic [2:0] bus_ctrl;
        logic addr_err;
        logic stack_err;
        logic trap_pend;
        logic abort_pend;
        icd_run_e run;
        logic [7:0][15:0] dcopy;
        logic [7:0][15:0] scopy;
        logic [15:0] dcopy_rd;
        logic [15:0] scopy_rd;
        icd_apb_rsp_s rsp;
        icd_class_s cls;
        icd_fields_s fld;
        icd_bus_e bus;
        logic go;
        logic abort;
        logic clr;
        logic ack;
        logic [1:0] tail;
    } icd_state_s;
endpackage

/* File: tb/icd_seq_model.sv */
`timescale 1ns/1ps
// Stand-in for the sequencer side: raises events, counts the decoder's pulses
module icd_seq_model
    import icd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic xfer_start,
    input wire logic transfer_abort,
    input wire logic clear_flags,
    input wire logic service_acknowledge,
    output logic [3:0] evt,
    output logic [7:0] n_xfer,
    output logic [7:0] n_abort,
    output logic [7:0] n_clr,
    output logic [7:0] n_ack
);
    // One-cycle pulse; bit order addr, stack, trap, abort
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        evt <= m;
        @(posedge pclk);
        evt <= 4'h0;
    endtask
    initial evt = 4'h0;
    // Counting, not flagging: a pulse stuck high shows up as an overcount
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_xfer <= 8'h00;
            n_abort <= 8'h00;
            n_clr <= 8'h00;
            n_ack <= 8'h00;
        end
        else
        begin
            n_xfer <= n_xfer + 8'(xfer_start);
            n_abort <= n_abort + 8'(transfer_abort);
            n_clr <= n_clr + 8'(clear_flags);
            n_ack <= n_ack + 8'(service_acknowledge);
        end
    end
endmodule

/* File: tb/instruction_class_decoder_tb.sv */
`timescale 1ns/1ps
`include "icd_consts.svh"
module instruction_class_decoder_tb
    import icd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic halt_flag = 1'b0;
    icd_apb_req_s req = '0;
    icd_apb_rsp_s rsp;
    icd_class_s cls;
    icd_fields_s fld;
    icd_bus_e bus;
    logic xs, ta, cf, sa, halted;
    logic [1:0] pdc;
    logic [15:0] gdr, gsr;
    logic [3:0] evt;
    logic [7:0] n_xfer, n_abort, n_clr, n_ack, c0, c1;
    logic [11:0] e;
    logic [31:0] r, f;
    logic perr;
    int n_errors = 0;
    int checks_done = 0;
    logic [15:0] words [16] = '{16'h0a03, 16'h8a8b, 16'h0bcb, 16'h1042, 16'h14c2, 16'h004b,
        16'h09cb, 16'hf08b, 16'h788b, 16'h708b, 16'h0d8b, 16'he08b, 16'hac8b, 16'h8d4b,
        16'h01ff, 16'h017f};
    logic [15:0] bw [5] = '{16'h1042, 16'h0a03, 16'h0bcb, 16'h8a8b, 16'h0a03};
    logic [2:0] bc [5] = '{3'h6, 3'h6, 3'h6, 3'h7, 3'h7};
    icd_bus_e be [5] = '{ICD_BUS_WRWORD, ICD_BUS_RDPAUSE, ICD_BUS_READ, ICD_BUS_WRBYTE,
        ICD_BUS_WRWORD};

    always #5 pclk = ~pclk;

    icd_decoder i_icd_decoder (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .addr_err_evt(evt[0]), .stack_err_evt(evt[1]), .trap_evt(evt[2]),
        .abort_evt(evt[3]), .console_halt_flag(halt_flag), .class_flags(cls),
        .fields(fld), .bus_cycle(bus), .xfer_start(xs), .transfer_abort(ta),
        .clear_flags(cf), .service_acknowledge(sa), .halted(halted),
        .post_dac_cycles(pdc), .dest_side_rd(gdr), .src_side_rd(gsr));

    icd_seq_model i_icd_seq_model (.pclk(pclk), .presetn(presetn), .xfer_start(xs),
        .transfer_abort(ta), .clear_flags(cf), .service_acknowledge(sa), .evt(evt),
        .n_xfer(n_xfer), .n_abort(n_abort), .n_clr(n_clr), .n_ack(n_ack));

    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // APB master; ready, read data and error are all taken at the rising edge
    task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        k = 0;
        @(posedge pclk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (rsp.pready !== 1'b1 && k < 50);
        // A slave that never answers counts as a mismatch
        if (rsp.pready !== 1'b1)
            n_errors++;
        q = rsp.prdata;
        perr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        xfer(a, 1'b0, 32'h0, q);
    endtask

    // Independent class model, bit order as the class flag struct
    function automatic logic [11:0] ref_cls(input logic [15:0] w);
        logic [3:0] g;
        logic [5:0] op;
        logic sg, eis, dbl, rmw, rdo, wro, dac, jmp, flt, byt, dm0, sm0;
        g = w[15:12];
        op = w[11:6];
        sg = g[2:0] == 3'h0;
        eis = g == 4'h7;
        dbl = g[2:0] != 3'h0 && g[2:0] != 3'h7;
        dm0 = w[5:3] == 3'h0;
        sm0 = w[11:9] == 3'h0;
        jmp = g == 4'h0 && (op == 6'o01 || op[5:3] == 3'o4);
        flt = g == 4'hf;
        rmw = sg && ((op == 6'o03 && !w[15]) || (op >= 6'o50 && op <= 6'o56)
            || (op >= 6'o60 && op <= 6'o63) || (op == 6'o67 && !w[15]));
        rmw = rmw || (eis && w[11:9] == 3'h4) || g inside {4'h4, 4'h5, 4'h6, 4'h9, 4'hc,
            4'hd, 4'he};
        rdo = (sg && (op == 6'o57 || op == 6'o65)) || (eis && w[11:10] == 2'h0)
            || g inside {4'h2, 4'h3, 4'ha, 4'hb};
        wro = g == 4'h1 || (sg && op == 6'o66);
        dac = jmp || (eis && w[11:9] <= 3'h4) || (dbl && sm0) || (sg && ((op == 6'o03
            && !w[15]) || (op >= 6'o50 && op <= 6'o65 && op != 6'o64)
            || (op == 6'o67 && !w[15])));
        byt = w[15] && ((sg && op != 6'o65 && op != 6'o66) || g inside {[4'h9:4'hd]});
        return {rmw, rdo, wro, dbl, dac, dac && dm0 && !jmp, jmp, flt, jmp || flt, byt,
            dm0, sm0};
    endfunction

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ICD_OFF_CLASS, r);
        chk(r, 32'h0000_1003);
        chk({30'h0, pdc}, 32'h2);
        // Decode table, register view and port view
        foreach (words[i])
        begin
            e = ref_cls(words[i]);
            wr(`ICD_OFF_IWORD, {16'h0, words[i]});
            rd(`ICD_OFF_CLASS, r);
            chk({20'h0, r[11:0]}, {20'h0, e});
            chk({20'h0, cls}, {20'h0, e});
            chk({30'h0, pdc}, e[3] ? 32'h1 : 32'h2);
            rd(`ICD_OFF_FIELDS, r);
            f = {4'h0, words[i][2:0], words[i][5:3], words[i][8:6], words[i][11:9],
                {7{words[i][7]}}, words[i][7:0], 1'b0};
            chk(r, f);
            chk({4'h0, fld}, f);
        end
        // Bus cycle choice under conditions 6 and 7
        foreach (bw[i])
        begin
            wr(`ICD_OFF_IWORD, {16'h0, bw[i]});
            c0 = n_xfer;
            wr(`ICD_OFF_UWORD, {29'h20, bc[i]});
            rd(`ICD_OFF_CLASS, r);
            chk({24'h0, n_xfer - c0}, 32'h1);
            chk({27'h0, bus}, {27'h0, be[i]});
            chk({27'h0, r[16:12]}, {27'h0, be[i]});
        end
        // Sticky flags, flag clear, pending abort blocking a transfer request, acknowledge
        i_icd_seq_model.pulse(4'hf);
        rd(`ICD_OFF_STATUS, r);
        chk({28'h0, r[3:0]}, 32'hf);
        c0 = n_clr;
        wr(`ICD_OFF_UWORD, 32'h0000_0018);
        rd(`ICD_OFF_STATUS, r);
        chk({28'h0, r[3:0]}, 32'hc);
        chk({24'h0, n_clr - c0}, 32'h1);
        c0 = n_xfer;
        c1 = n_abort;
        wr(`ICD_OFF_UWORD, 32'h0000_0106);
        rd(`ICD_OFF_STATUS, r);
        chk({24'h0, n_abort - c1}, 32'h1);
        chk({24'h0, n_xfer - c0}, 32'h0);
        c0 = n_ack;
        wr(`ICD_OFF_CTRL, 32'h0000_0001);
        rd(`ICD_OFF_STATUS, r);
        chk({28'h0, r[3:0]}, 32'h0);
        chk({24'h0, n_ack - c0}, 32'h1);
        // Console halt drops a transfer request
        halt_flag <= 1'b1;
        rd(`ICD_OFF_STATUS, r);
        chk({31'h0, r[4]}, 32'h1);
        chk({31'h0, halted}, 32'h1);
        c0 = n_xfer;
        wr(`ICD_OFF_UWORD, 32'h0000_0106);
        rd(`ICD_OFF_STATUS, r);
        chk({24'h0, n_xfer - c0}, 32'h0);
        halt_flag <= 1'b0;
        wr(`ICD_OFF_UWORD, 32'h0000_0106);
        rd(`ICD_OFF_STATUS, r);
        chk({24'h0, n_xfer - c0}, 32'h1);
        // Both copies written; swapping the fields must show each value on both sides
        wr(`ICD_OFF_GRWR, 32'h0003_beef);
        wr(`ICD_OFF_GRWR, 32'h0005_1234);
        wr(`ICD_OFF_IWORD, 32'h0000_0143);
        rd(`ICD_OFF_GRRD, r);
        chk(r, 32'h1234_beef);
        chk({gsr, gdr}, 32'h1234_beef);
        wr(`ICD_OFF_IWORD, 32'h0000_00c5);
        rd(`ICD_OFF_GRRD, r);
        chk(r, 32'hbeef_1234);
        // Read-only class register ignores writes, write-only control reads zero
        wr(`ICD_OFF_CLASS, 32'hffff_ffff);
        rd(`ICD_OFF_CLASS, r);
        chk({20'h0, r[11:0]}, {20'h0, ref_cls(16'h00c5)});
        rd(`ICD_OFF_CTRL, r);
        chk(r, 32'h0);
        chk({31'h0, perr}, 32'h0);
        // Unmapped offset answers with an error and no data
        rd(5'h02, r);
        chk({31'h0, perr}, 32'h1);
        finish_test();
    end
endmodule
